// ==== src/olm_pkg.sv ====
// Purpose: shared constants for the on-hook line monitor
// Assumes: 25 MHz system clock, 32-bit APB register port
// Notes:   voltages are held in half-volt units (2 pulses per volt per ms)
package olm_pkg;
    // clock and measurement timing
    localparam int          CLK_KHZ        = 25000;
    localparam int          WINDOW_US      = 1000;    // frequency gate time
    localparam int          WINDOW_CYC     = (CLK_KHZ * WINDOW_US) / 1000;
    localparam logic [3:0]  RING_HOLD_WIN  = 4'h3;    // ring hold after the setting window, in windows; least ring pulse is 4 windows
    localparam int          AVG_SHIFT      = 4;       // averaging time constant 2^4 ms

    // encoding limits, in half-volt units
    localparam logic [9:0]  MIN_CNT        = 10'h006; // 3 V, lowest valid reading
    localparam logic [9:0]  MAX_CNT        = 10'h3ff; // saturation ceiling

    // register byte offsets
    localparam logic [11:0] CTRL_OFS       = 12'h000;
    localparam logic [11:0] STATUS_OFS     = 12'h004;

    // control field positions
    localparam int          CTRL_SRC_BIT   = 0;
    localparam int          CTRL_RTH_LSB   = 1;
    localparam int          CTRL_LIU_LSB   = 3;
    localparam int          CTRL_SNOOP_GAIN_SELECT_BIT = 5;
    localparam int          CTRL_IRQEN_BIT = 6;
    localparam logic [6:0]  CTRL_RESET     = 7'h68;   // irq on, 0 dB, liu 15 V, ring 10 V

    // status field positions
    localparam int          ST_RING_BIT    = 0;
    localparam int          ST_POL_BIT     = 1;
    localparam int          ST_LIU_BIT     = 2;
    localparam int          ST_LINE_ACTIVITY_FLAG_BIT    = 3;
    localparam int          ST_MAG_LSB     = 16;

    // thresholds, half-volt units
    localparam logic [11:0] RING_THR0      = 12'h014; // 10 V
    localparam logic [11:0] RING_THR1      = 12'h01e; // 15 V
    localparam logic [11:0] RING_THR2      = 12'h02d; // 22.5 V
    localparam logic [11:0] RING_THR3      = 12'h03c; // 30 V
    localparam logic [9:0]  LIU_LVL0       = 10'h005; // 2.5 V
    localparam logic [9:0]  LIU_LVL1       = 10'h01e; // 15 V
    localparam logic [9:0]  LIU_LVL2       = 10'h02d; // 22.5 V
    localparam logic [9:0]  LIU_LVL3       = 10'h03c; // 30 V
    localparam logic [11:0] LINE_ACTIVITY_FLAG_THR       = 12'h01e; // 15 V step
endpackage

// ==== src/olm_sync.sv ====
// Purpose: two-stage synchroniser for a level from outside the clock domain
// Assumes: input may change at any time
// Notes:   only the second stage leaves this module
`timescale 1ns/1ps
module olm_sync (
    // clock and reset
    input  wire logic clk_in,
    input  wire logic rst_b_in,
    // level
    input  wire logic d_in,
    output logic      q_out
);
    logic meta;

    // first stage feeds the second and nothing else
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            meta  <= 1'b0;
            q_out <= 1'b0;
        end else begin
            meta  <= d_in;
            q_out <= meta;
        end
    end
endmodule

// ==== src/olm_line_monitor.sv ====
// Purpose: decode the isolated pulse train into on-hook line status
// Assumes: pulse rate 2 kHz per volt, duty above half for positive polarity
// Notes:   one reading per gate window; status and control over APB
//
// Chosen here: the APB register port and the register offsets.
`timescale 1ns/1ps
module olm_line_monitor
    import olm_pkg::*;
#(
    parameter int WIN_CYC = WINDOW_CYC
) (
    // clock and reset
    input  wire logic        clk_in,
    input  wire logic        rst_b_in,
    // apb slave
    input  wire logic        psel_in,
    input  wire logic        penable_in,
    input  wire logic        pwrite_in,
    input  wire logic [11:0] paddr_in,
    input  wire logic [31:0] pwdata_in,
    output logic [31:0]      prdata_out,
    output logic             pready_out,
    output logic             pslverr_out,
    // isolation barrier pulse train
    input  wire logic        barrier_pulse_in,
    // line status pin, open drain
    output logic             line_status_irq_out,
    output logic             line_status_irq_oe_b_out,
    // snoop path gain control
    output logic             snoop_gain_select_out
);
    // pulse train capture
    logic        pulse_s;
    logic        pulse_d;
    logic [15:0] win_cnt;
    logic [9:0]  pulse_cnt;
    logic [15:0] hi_acc;
    logic [15:0] lo_acc;
    logic        win_end;
    logic        win_d1;
    // decoded line
    logic [9:0]  mag;
    logic        pol;
    logic signed [15:0] avg;
    logic signed [11:0] line_activity_flag_ref;
    logic [3:0]  ring_hold;
    // flags and control
    logic        ring_detect_bit;
    logic        line_polarity_flag;
    logic        line_in_use_flag;
    logic        line_activity_flag;
    logic [6:0]  ctrl;
    logic        irq_act;

    olm_sync u_sync (
        .clk_in   (clk_in),
        .rst_b_in (rst_b_in),
        .d_in     (barrier_pulse_in),
        .q_out    (pulse_s)
    );

    // window and edge decode
    wire         pulse_rise  = pulse_s & ~pulse_d;
    wire         win_last    = (win_cnt == 16'(WIN_CYC - 1));
    assign       win_end     = win_last;
    wire [9:0]   cnt_inc     = (pulse_cnt == MAX_CNT) ? pulse_cnt : pulse_cnt + 10'h001;

    // control fields
    wire         status_pin_source_select = ctrl[CTRL_SRC_BIT];
    wire [1:0]   ring_sel    = ctrl[CTRL_RTH_LSB +: 2];
    wire [1:0]   liu_sel     = ctrl[CTRL_LIU_LSB +: 2];
    wire         irq_en      = ctrl[CTRL_IRQEN_BIT];
    assign       snoop_gain_select_out = ctrl[CTRL_SNOOP_GAIN_SELECT_BIT];

    // threshold selection
    wire [11:0]  ring_thr    = (ring_sel == 2'h0) ? RING_THR0 :
                               (ring_sel == 2'h1) ? RING_THR1 :
                               (ring_sel == 2'h2) ? RING_THR2 : RING_THR3;
    wire [9:0]   liu_lvl     = (liu_sel == 2'h0) ? LIU_LVL0 :
                               (liu_sel == 2'h1) ? LIU_LVL1 :
                               (liu_sel == 2'h2) ? LIU_LVL2 : LIU_LVL3;

    // signed line voltage, its departure from average and from the activity reference
    wire signed [11:0] sv        = pol ? $signed({2'h0, mag}) : -$signed({2'h0, mag});
    wire signed [11:0] avg_int   = avg[15:AVG_SHIFT];
    wire signed [12:0] ring_diff = 13'(sv) - 13'(avg_int);
    wire signed [12:0] line_activity_flag_diff = 13'(sv) - 13'(line_activity_flag_ref);
    wire [12:0]  line_activity_flag_abs    = line_activity_flag_diff[12] ? 13'(-line_activity_flag_diff) : 13'(line_activity_flag_diff);
    wire signed [15:0] avg_step  = ($signed({sv, 4'h0}) - avg) >>> AVG_SHIFT;
    wire         ring_raw    = ring_diff > $signed({1'b0, ring_thr});
    wire         line_activity_flag_raw    = line_activity_flag_abs > {1'b0, LINE_ACTIVITY_FLAG_THR};

    // apb decode
    wire         apb_setup   = psel_in & ~penable_in;
    wire         apb_access  = psel_in & penable_in;
    wire         hit_ctrl    = (paddr_in == CTRL_OFS);
    wire         hit_status  = (paddr_in == STATUS_OFS);
    wire         hit_any     = hit_ctrl | hit_status;
    wire         ctrl_wr     = apb_access & pwrite_in & hit_ctrl;
    wire [31:0]  status_word = {6'h00, mag, 12'h000,
                                line_activity_flag, line_in_use_flag,
                                line_polarity_flag, ring_detect_bit};
    wire [31:0]  rd_word     = hit_ctrl   ? {25'h0, ctrl} :
                               hit_status ? status_word : 32'h0;
    assign       pready_out  = 1'b1;                 // every access ends in one cycle
    assign       pslverr_out = apb_access & ~hit_any;

    // status pin source and gating
    assign       irq_act     = irq_en & (status_pin_source_select ? ring_detect_bit
                                                                  : line_activity_flag);

    // input edge memory and gate window counter
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            pulse_d <= 1'b0;
            win_cnt <= 16'h0000;
            win_d1  <= 1'b0;
        end else begin
            pulse_d <= pulse_s;
            win_cnt <= win_last ? 16'h0000 : win_cnt + 16'h0001;
            win_d1  <= win_end;
        end
    end

    // count pulses and high/low time in each window
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            pulse_cnt <= 10'h000;
            hi_acc    <= 16'h0000;
            lo_acc    <= 16'h0000;
        end else if (win_end) begin
            // the last cycle's sample opens the next window, so no edge is lost
            pulse_cnt <= pulse_rise ? 10'h001 : 10'h000;
            hi_acc    <= {15'h0000, pulse_s};
            lo_acc    <= {15'h0000, ~pulse_s};
        end else begin
            pulse_cnt <= pulse_rise ? cnt_inc : pulse_cnt;
            hi_acc    <= hi_acc + {15'h0000, pulse_s};
            lo_acc    <= lo_acc + {15'h0000, ~pulse_s};
        end
    end

    // one reading per window: two counts per volt per millisecond, duty gives sign
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            mag <= 10'h000;
            pol <= 1'b1;
        end else if (win_end) begin
            mag <= (pulse_cnt < MIN_CNT) ? 10'h000 : pulse_cnt;
            if (pulse_cnt != 10'h000) begin
                pol <= hi_acc >= lo_acc;
            end
        end
    end

    // averaged line voltage, a slow filter so ringing rides above it
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            avg <= 16'sh0000;
        end else if (win_d1) begin
            avg <= avg + avg_step;
        end
    end

    // ring detect: one-sided departure, held a minimum time so a slow
    // sine still gives one clean pulse per cycle
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            ring_detect_bit <= 1'b0;
            ring_hold       <= 4'h0;
        end else if (win_d1) begin
            if (ring_raw) begin
                ring_detect_bit <= 1'b1;
                ring_hold       <= RING_HOLD_WIN;
            end else if (ring_hold != 4'h0) begin
                ring_hold       <= ring_hold - 4'h1;
            end else begin
                ring_detect_bit <= 1'b0;
            end
        end
    end

    // line in use, polarity and full-wave activity flags
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            line_in_use_flag   <= 1'b0;
            line_polarity_flag <= 1'b1;
            line_activity_flag <= 1'b0;
            line_activity_flag_ref           <= 12'sh000;
        end else if (win_d1) begin
            line_in_use_flag   <= mag > liu_lvl;
            line_polarity_flag <= pol;
            line_activity_flag <= line_activity_flag_raw;
            if (line_activity_flag_raw) begin
                line_activity_flag_ref <= sv;   // follow the step so a steady line goes quiet again
            end
        end
    end

    // control register
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            ctrl <= CTRL_RESET;
        end else if (ctrl_wr) begin
            ctrl <= pwdata_in[6:0];
        end
    end

    // read data captured in setup so it is stable through the access phase
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            prdata_out <= 32'h0;
        end else if (apb_setup) begin
            prdata_out <= rd_word;
        end
    end

    // open-drain status pin: drive low only when active, released otherwise
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            line_status_irq_out      <= 1'b0;
            line_status_irq_oe_b_out <= 1'b1;
        end else begin
            line_status_irq_out      <= 1'b0;
            line_status_irq_oe_b_out <= ~irq_act;
        end
    end

    // checks
    mag_count_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
        win_end && pulse_cnt >= MIN_CNT |=> mag == $past(pulse_cnt))
        else $error("magnitude does not follow pulse count");

    low_volt_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
        win_end && pulse_cnt < MIN_CNT |=> mag == 10'h000)
        else $error("reading below floor not zeroed");

    polarity_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
        win_end && pulse_cnt != 10'h000 && hi_acc < lo_acc |=> ##1 !line_polarity_flag)
        else $error("low duty not reported as negative");

    ring_set_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
        win_d1 && ring_raw |=> ring_detect_bit && ring_hold == RING_HOLD_WIN)
        else $error("ring not raised on departure");

    ring_hold_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
        $fell(ring_detect_bit) |-> $past(ring_hold) == 4'h0)
        else $error("ring pulse dropped early");

    liu_level_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
        win_d1 && mag > liu_lvl |=> line_in_use_flag)
        else $error("line in use missed");

    line_activity_flag_step_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
        win_d1 && line_activity_flag_raw |=> line_activity_flag && line_activity_flag_ref == $past(sv))
        else $error("activity step missed");

    irq_route_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
        irq_en && !status_pin_source_select && line_activity_flag
        |=> !line_status_irq_oe_b_out && !line_status_irq_out)
        else $error("activity not routed to pin");

    irq_mask_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
        !irq_en |=> line_status_irq_oe_b_out)
        else $error("pin driven while disabled");

    status_read_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
        apb_setup && hit_status ##1 apb_access
        |-> prdata_out[ST_RING_BIT] == $past(ring_detect_bit))
        else $error("ring status not read back");
endmodule

// ==== verification/olm_line_model.sv ====
// Purpose: line side of the barrier, turns a line condition into a pulse train
// Assumes: period is a whole number of clocks, zero for a dead line
// Notes:   runs free like the real encoder; periods of 5 or more keep both phases >= 2
`timescale 1ns/1ps
module olm_line_model (
    // clock
    input  wire logic       clk_in,
    // line condition
    input  wire logic [7:0] period_in,
    input  wire logic       positive_in,
    // pulse train across the barrier
    output logic            pulse_out
);
    logic [7:0] phase = 8'h00;
    logic [7:0] high_len;

    // duty above half for positive polarity, below for negative
    assign high_len = positive_in ? (period_in - 8'h02) : 8'h02;
    // one pulse per period, rate set by the line voltage
    always @(posedge clk_in) begin
        phase <= (phase + 8'h01 >= period_in) ? 8'h00 : phase + 8'h01;
    end
    // a dead line sends nothing, so the barrier rests low
    assign pulse_out = (period_in != 8'h00) && (phase < high_len);
endmodule

// ==== verification/tb_top.sv ====
// Purpose: self-checking bench for the on-hook line monitor
// Assumes: gate window cut to 250 clocks so a short run covers many readings
// Notes:   test periods divide the window, so every magnitude reading is exact
`timescale 1ns/1ps
module tb_top
    import olm_pkg::*;
;
    localparam int WIN = 250;
    logic        clk_in, rst_b_in, psel, penable, pwrite, pready, pslverr, err;
    logic        pulse, irq, irq_oe_b, snoop_gain_select, positive;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [7:0]  period;
    int          num_errors, checks;

    olm_line_monitor #(.WIN_CYC(WIN)) dut (.clk_in(clk_in), .rst_b_in(rst_b_in),
        .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr),
        .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
        .barrier_pulse_in(pulse), .line_status_irq_out(irq),
        .line_status_irq_oe_b_out(irq_oe_b), .snoop_gain_select_out(snoop_gain_select));
    olm_line_model line (.clk_in(clk_in), .period_in(period), .positive_in(positive),
        .pulse_out(pulse));

    // 25 MHz clock
    always #20 clk_in = ~clk_in;

    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("unexpected at %0t: %s seen %h wanted %h", $time, what, seen, exp);
        end
    endtask

    task automatic results();
        $display("comparisons %0d mismatches %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // one apb transfer; the master never assumes how soon pready comes
    task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        @(posedge clk_in);
        penable <= 1'b1;
        @(posedge clk_in);
        while (pready !== 1'b1) begin
            n++;
            if (n > 16) begin
                check(32'h0, 32'h1, "apb timeout");
                results();
            end
            @(posedge clk_in);
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk_in);
    endtask

    // pin level within four windows, bounded
    task automatic wait_pin(input logic lvl, input string what);
        int n;
        n = 0;
        while (irq_oe_b !== lvl && n < 4 * WIN) begin
            n++;
            @(posedge clk_in);
        end
        check({30'h0, irq, irq_oe_b}, {31'h0, lvl}, what);
        if (n >= 4 * WIN) begin
            results();
        end
    endtask

    // host ring qualifier: one gate window stands for one millisecond
    int   tick = 0, gap_ms = 0, valid_run = 0, on_ms = 0;
    logic oe_q = 1'b1;
    always @(posedge clk_in) begin
        oe_q <= irq_oe_b;
        tick <= (tick == WIN - 1) ? 0 : tick + 1;
        if (oe_q && !irq_oe_b) begin
            gap_ms    <= 0;
            valid_run <= (gap_ms >= 12 && gap_ms <= 74) ? valid_run + 1 : 0;
        end else if (tick == WIN - 1) begin
            gap_ms <= gap_ms + 1;
            if (gap_ms > 74) begin
                valid_run <= 0;
                on_ms     <= 0;
            end else begin
                on_ms <= on_ms + (irq_oe_b ? 0 : 1);
            end
        end
    end

    function automatic logic [9:0] exp_mag(input logic [7:0] p);
        return (WIN / p < 6) ? 10'h000 : 10'(WIN / p);
    endfunction

    function automatic logic exp_liu(input logic [9:0] m, input logic [1:0] s);
        logic [9:0] lvl[4];
        lvl = '{LIU_LVL0, LIU_LVL1, LIU_LVL2, LIU_LVL3};
        return m > lvl[s];
    endfunction

    initial begin
        logic [7:0] pers[4];
        logic [6:0] c;
        logic [9:0] m;
        pers = '{8'd5, 8'd10, 8'd25, 8'd50};
        clk_in = 1'b0;
        rst_b_in = 1'b0;
        {psel, penable, pwrite, paddr, pwdata, period, positive} = '0;
        num_errors = 0;
        checks = 0;
        void'($urandom(32'hb172));
        repeat (12) @(posedge clk_in);
        rst_b_in <= 1'b1;
        @(posedge clk_in);
        apb(CTRL_OFS, 1'b0, 32'h0);
        check(rd, {25'h0, CTRL_RESET}, "ctrl reset");
        check({31'h0, snoop_gain_select}, 32'h1, "gain reset");
        check({30'h0, irq, irq_oe_b}, 32'h1, "pin released");
        // unmapped place refuses both directions
        apb(12'h008, 1'b1, 32'hffff_ffff);
        check({31'h0, err}, 32'h1, "unmapped write");
        apb(12'h008, 1'b0, 32'h0);
        check({err, rd[30:0]}, 32'h8000_0000, "unmapped read");
        $display("test registers: reset and unmapped done");
        // random control words, gain bit forced both ways
        for (int i = 0; i < 6; i++) begin
            c = 7'($urandom);
            c[5] = i[0];
            apb(CTRL_OFS, 1'b1, {25'h0, c});
            apb(CTRL_OFS, 1'b0, 32'h0);
            check(rd, {25'h0, c}, "ctrl readback");
            check({31'h0, snoop_gain_select}, {31'h0, c[5]}, "snoop gain");
        end
        $display("test control readback done");
        // every rate, both polarities, every in-use level
        for (int i = 0; i < 8; i++) begin
            period <= pers[i % 4];
            positive <= i[2];
            m = exp_mag(pers[i % 4]);
            for (int s = 0; s < 4; s++) begin
                apb(CTRL_OFS, 1'b1, {25'h0, 2'b01, s[1:0], 3'h0});
                repeat (3 * WIN) @(posedge clk_in);
                apb(STATUS_OFS, 1'b0, 32'h0);
                check({22'h0, rd[25:16]}, {22'h0, m}, "magnitude");
                check({31'h0, (m == 0) ? i[2] : rd[ST_POL_BIT]}, {31'h0, i[2]}, "pol");
                check({31'h0, rd[ST_LIU_BIT]}, {31'h0, exp_liu(m, s[1:0])}, "in use");
            end
        end
        $display("test magnitude, polarity and in-use done");
        // settle at 5 V, then a 20 V rise
        period <= 8'd25;
        positive <= 1'b1;
        // host picks the 15 V ring threshold
        apb(CTRL_OFS, 1'b1, 32'h62);
        repeat (40 * WIN) @(posedge clk_in);
        check({30'h0, irq, irq_oe_b}, 32'h1, "quiet pin");
        period <= 8'd5;
        wait_pin(1'b0, "activity pin");
        apb(STATUS_OFS, 1'b0, 32'h0);
        check({28'h0, rd[3:0]} & 32'h9, 32'h9, "activity and ring");
        apb(CTRL_OFS, 1'b1, 32'h63);
        wait_pin(1'b0, "ring pin");
        repeat (2 * WIN) @(posedge clk_in);
        apb(STATUS_OFS, 1'b0, 32'h0);
        check({31'h0, rd[ST_RING_BIT]}, 32'h1, "ring held");
        apb(CTRL_OFS, 1'b1, 32'h21);
        wait_pin(1'b1, "pin disabled");
        $display("test rising step done");
        // settle at 25 V, then a 20 V fall: full-wave activity, no ring
        apb(CTRL_OFS, 1'b1, 32'h60);
        repeat (60 * WIN) @(posedge clk_in);
        apb(STATUS_OFS, 1'b0, 32'h0);
        check({28'h0, rd[3:0]} & 32'h9, 32'h0, "settled flags");
        period <= 8'd25;
        wait_pin(1'b0, "fall activity");
        apb(STATUS_OFS, 1'b0, 32'h0);
        check({31'h0, rd[ST_RING_BIT]}, 32'h0, "no ring on fall");
        $display("test falling step done");
        // ring cadence on the pin: 20 ms cycles qualify, 8 ms cycles are refused
        apb(CTRL_OFS, 1'b1, 32'h61);
        for (int i = 0; i < 14; i++) begin
            period <= i[0] ? 8'd0 : 8'd5;
            repeat (((i < 8) ? 10 : 4) * WIN) @(posedge clk_in);
            if (i == 7) begin
                check({31'h0, valid_run >= 2}, 32'h1, "ring qualified");
                check({31'h0, on_ms > 0 && on_ms <= 2000}, 32'h1, "burst");
            end
        end
        check(valid_run, 32'h0, "short periods refused");
        $display("test ring cadence done");
        results();
    end
endmodule
